// ---- spp_cfg.svh ----
// Purpose: constants for the sum-of-products macrocell array
// Assumes: 32-bit classic Wishbone, byte addresses
// Notes: fuse words pair up per product term, low word first
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SPP_N_DED 12
`define SPP_N_MC 10
`define SPP_N_SIG 22
`define SPP_N_LIT 44
`define SPP_N_TERM 132
`define SPP_TERM_MIN 8
`define SPP_TERM_STEP 2
`define SPP_TERM_AR 0
`define SPP_TERM_SP 131

// ----------------------------------------
// register map
// ----------------------------------------
`define SPP_ADR_FUSE_BASE 12'h000
`define SPP_ADR_FUSE_END 12'h420
`define SPP_ADR_CFG 12'h800
`define SPP_ADR_STAT 12'h804
`define SPP_ADR_PINS 12'h808

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPP_CFG_BYPASS_LSB 0
`define SPP_CFG_POL_LSB 10
`define SPP_STAT_Q_LSB 0
`define SPP_STAT_OE_LSB 10
`define SPP_PINS_DED_LSB 0
`define SPP_PINS_IO_LSB 12
`define SPP_CFG_RESET 32'h0000_0000
`define SPP_FUSE_RESET 44'hFFF_FFFF_FFFF

`endif

// ---- spp_pkg.sv ----
// Purpose: shared types for the sum-of-products macrocell array
// Assumes: spp_cfg.svh supplies the numbers
// Notes: none
`include "spp_cfg.svh"
package spp_pkg;
    typedef logic [`SPP_N_LIT-1:0] spp_term_t;
    typedef logic [`SPP_N_DED-1:0] spp_ded_t;
    typedef logic [`SPP_N_MC-1:0] spp_mc_t;
    typedef enum logic {SPP_BUS_IDLE, SPP_BUS_ACK} spp_bus_t;

    // sum terms per macrocell: pairs of 8,10,12,14,16 mirrored
    function automatic int spp_size(input int m);
        int d;
        d = (m < `SPP_N_MC - 1 - m) ? m : `SPP_N_MC - 1 - m;
        return `SPP_TERM_MIN + `SPP_TERM_STEP * d;
    endfunction

    // index of macrocell m's enable term; its sum terms follow it
    function automatic int spp_base(input int m);
        int b;
        b = `SPP_TERM_AR + 1;
        for (int j = 0; j < m; j++) begin
            b = b + spp_size(j) + 1;
        end
        return b;
    endfunction
endpackage

// ---- spp_macrocell.sv ----
// Purpose: one output macrocell: register, bypass, polarity, enable, feedback
// Assumes: terms arrive already evaluated on ref_clk_in's side
// Notes: the clear term acts without the clock
`timescale 1ns/1ps
module spp_macrocell #(
    parameter int NTERMS = 8
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // terms
    input wire logic [NTERMS-1:0] terms_in,
    input wire logic oe_term_in,
    input wire logic ar_term_in,
    input wire logic sp_term_in,
    // configuration
    input wire logic bypass_in,
    input wire logic pol_in,
    // pin and feedback
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic fb_out,
    output logic q_out
);
    import spp_pkg::*;

    logic q;
    logic next_q;
    logic sum;

    // ----------------------------------------
    // register
    // ----------------------------------------
    always_comb begin
        sum = |terms_in;
        next_q = sp_term_in ? 1'b1 : sum;
    end

    // clear term is combinational; glitches on it will clear, as on the part
    always_ff @(posedge ref_clk_in or negedge nrst_in or posedge ar_term_in) begin
        if (!nrst_in) begin
            q <= 1'b0;
        end else if (ar_term_in) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // output and feedback
    // ----------------------------------------
    always_comb begin
        logic val;
        val = bypass_in ? sum : q;
        pin_out = pol_in ? val : ~val;
        pin_oe_out = oe_term_in;
        if (!bypass_in) begin
            fb_out = q;
        end else if (oe_term_in) begin
            fb_out = pin_out;
        end else begin
            fb_out = pin_in;
        end
        q_out = q;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_load;
        !sp_term_in && !ar_term_in ##1 !ar_term_in;
    endsequence

    property p_capture;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_load |-> q == $past(sum);
    endproperty
    a_capture: assert property (p_capture) else $error("register missed its sum");

    property p_preset;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        sp_term_in && !ar_term_in ##1 !ar_term_in |-> q;
    endproperty
    a_preset: assert property (p_preset) else $error("preset did not set register");

    property p_clear;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        $past(ar_term_in) && ar_term_in |-> !q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear term left register set");

    property p_reg_out;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !bypass_in |-> pin_out == (pol_in ? q : ~q) && fb_out == q;
    endproperty
    a_reg_out: assert property (p_reg_out) else $error("registered output wrong");

    property p_comb_out;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        bypass_in && oe_term_in |-> pin_out == (pol_in ? sum : ~sum) && fb_out == pin_out;
    endproperty
    a_comb_out: assert property (p_comb_out) else $error("combinational output wrong");

    property p_comb_fb_pin;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        bypass_in && !oe_term_in |-> fb_out == pin_in && !pin_oe_out;
    endproperty
    a_comb_fb_pin: assert property (p_comb_fb_pin) else $error("feedback not from pin");
endmodule

// ---- spp_array.sv ----
// Purpose: programmable and-or array with ten output macrocells
// Assumes: fuses and configuration loaded over classic Wishbone
// Notes: a fuse bit of 1 keeps its literal in the term
//
// Contract
// - twenty-two array inputs, ten pins that each may also be inputs.
// - five pairs of sum sizes, eight to sixteen terms in steps of two.
// - each macrocell delivers either its register or its raw sum.
// - each macrocell's output polarity is chosen on its own.
// - each pin driver is enabled by its own product term.
// - one shared preset term sets registers at the next clock edge.
// - one shared reset term clears registers at once, outside normal terms.
// - at power-up every macrocell register starts cleared without outside help; here the registers are cleared only while nrst_in is low.
// - registered macrocells feed their register value back into the array.
// - combinational feedback is the result when enabled, else the pin level.
// - two bits per macrocell pick registered or combinational, low or high.
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_array (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // dedicated inputs
    input wire spp_pkg::spp_ded_t ded_in,
    // two-way pins
    input wire spp_pkg::spp_mc_t io_in,
    output spp_pkg::spp_mc_t io_out,
    output spp_pkg::spp_mc_t io_oe_out
);
    import spp_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    spp_ded_t ded_s1;
    spp_ded_t ded_s;
    spp_mc_t io_s1;
    spp_mc_t io_s;
    spp_ded_t next_ded_s1;
    spp_ded_t next_ded_s;
    spp_mc_t next_io_s1;
    spp_mc_t next_io_s;

    always_comb begin
        next_ded_s1 = ded_in;
        next_ded_s = ded_s1;
        next_io_s1 = io_in;
        next_io_s = io_s1;
    end

    // two stages cost two cycles of pin latency against the 50 ns clock
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ded_s1 <= '0;
            ded_s <= '0;
            io_s1 <= '0;
            io_s <= '0;
        end else begin
            ded_s1 <= next_ded_s1;
            ded_s <= next_ded_s;
            io_s1 <= next_io_s1;
            io_s <= next_io_s;
        end
    end

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    spp_bus_t bus;
    spp_bus_t next_bus;
    logic [31:0] dat_r;
    logic [31:0] next_dat_r;
    logic [31:0] cfg;
    logic [31:0] next_cfg;
    logic req;
    logic wr;
    logic fuse_hit;
    logic [8:0] word;
    logic [7:0] fidx;
    logic fuse_we;
    spp_term_t fuse_new;
    spp_term_t fuse [0:`SPP_N_TERM-1];
    spp_mc_t mc_q;
    spp_mc_t mc_fb;
    spp_term_t lit;
    logic [`SPP_N_TERM-1:0] term_val;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] cur;
        logic [31:0] mrg;
        req = wb_cyc_in && wb_stb_in;
        wr = req && wb_we_in && (bus == SPP_BUS_ACK);
        fuse_hit = (wb_adr_in < `SPP_ADR_FUSE_END);
        word = wb_adr_in[10:2];
        fidx = word[8:1];
        cur = word[0] ? {20'h0_0000, fuse[fidx][43:32]} : fuse[fidx][31:0];
        mrg = merge(cur, wb_dat_in, wb_sel_in);
        fuse_new = word[0] ? {mrg[11:0], fuse[fidx][31:0]} : {fuse[fidx][43:32], mrg};
        fuse_we = wr && fuse_hit;
        next_cfg = cfg;
        if (wr && wb_adr_in == `SPP_ADR_CFG) begin
            next_cfg = merge(cfg, wb_dat_in, wb_sel_in) & 32'h000F_FFFF;
        end
        next_bus = SPP_BUS_IDLE;
        next_dat_r = dat_r;
        if (bus == SPP_BUS_IDLE && req) begin
            next_bus = SPP_BUS_ACK;
            if (fuse_hit) begin
                next_dat_r = cur;
            end else if (wb_adr_in == `SPP_ADR_CFG) begin
                next_dat_r = cfg;
            end else if (wb_adr_in == `SPP_ADR_STAT) begin
                next_dat_r = {12'h000, io_oe_out, mc_q};
            end else if (wb_adr_in == `SPP_ADR_PINS) begin
                next_dat_r = {10'h000, io_s, ded_s};
            end else begin
                next_dat_r = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus <= SPP_BUS_IDLE;
            dat_r <= 32'h0000_0000;
            cfg <= `SPP_CFG_RESET;
        end else begin
            bus <= next_bus;
            dat_r <= next_dat_r;
            cfg <= next_cfg;
        end
    end

    // erased fuses keep every literal, so each term is false until programmed
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int t = 0; t < `SPP_N_TERM; t++) begin
                fuse[t] <= `SPP_FUSE_RESET;
            end
        end else if (fuse_we) begin
            fuse[fidx] <= fuse_new;
        end
    end

    assign wb_ack_out = (bus == SPP_BUS_ACK);
    assign wb_dat_out = dat_r;

    // ----------------------------------------
    // and array
    // ----------------------------------------
    // comb feedback may close a loop through the array if programmed so
    always_comb begin
        logic [`SPP_N_SIG-1:0] sig;
        sig = {mc_fb, ded_s};
        for (int k = 0; k < `SPP_N_SIG; k++) begin
            lit[2*k] = sig[k];
            lit[2*k+1] = ~sig[k];
        end
        for (int t = 0; t < `SPP_N_TERM; t++) begin
            term_val[t] = &(~fuse[t] | lit);
        end
    end

    // ----------------------------------------
    // macrocells
    // ----------------------------------------
    for (genvar m = 0; m < `SPP_N_MC; m++) begin : g_mc
        localparam int NT = spp_size(m);
        localparam int BASE = spp_base(m);
        spp_macrocell #(
            .NTERMS(NT)
        ) u_mc (
            .ref_clk_in(ref_clk_in),
            .nrst_in(nrst_in),
            .terms_in(term_val[BASE+1 +: NT]),
            .oe_term_in(term_val[BASE]),
            .ar_term_in(term_val[`SPP_TERM_AR]),
            .sp_term_in(term_val[`SPP_TERM_SP]),
            .bypass_in(cfg[`SPP_CFG_BYPASS_LSB + m]),
            .pol_in(cfg[`SPP_CFG_POL_LSB + m]),
            .pin_in(io_s[m]),
            .pin_out(io_out[m]),
            .pin_oe_out(io_oe_out[m]),
            .fb_out(mc_fb[m]),
            .q_out(mc_q[m])
        );
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic up_seen;
    logic next_up_seen;
    always_comb begin
        next_up_seen = 1'b1;
    end
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            up_seen <= 1'b0;
        end else begin
            up_seen <= next_up_seen;
        end
    end

    property p_power_up;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !up_seen |-> mc_q == 10'h000;
    endproperty
    a_power_up: assert property (p_power_up) else $error("registers not cleared at reset");

    sequence s_req_start;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence

    property p_ack;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_req_start |=> wb_ack_out ##1 !wb_ack_out;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not a single cycle after request");

    property p_cfg_write;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        wb_ack_out && wb_we_in && wb_cyc_in && wb_stb_in && wb_adr_in == `SPP_ADR_CFG
        && wb_sel_in == 4'hF |=> cfg == ($past(wb_dat_in) & 32'h000F_FFFF);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("mode bits not written");

    property p_sync;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        up_seen && $past(up_seen) |-> ded_s == $past(ded_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("dedicated input latency wrong");

    property p_oe_term;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        io_oe_out[0] == term_val[`SPP_TERM_AR + 1] && io_oe_out[9] == term_val[spp_base(9)];
    endproperty
    a_oe_term: assert property (p_oe_term) else $error("pin enable not from its term");

    sequence s_read_start;
        wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in;
    endsequence

    property p_cfg_read;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_read_start ##0 wb_adr_in == `SPP_ADR_CFG |=> wb_dat_out == $past(cfg);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("mode bits read back wrong");

    property p_stat_read;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_read_start ##0 wb_adr_in == `SPP_ADR_STAT
        |=> wb_dat_out == {12'h000, $past(io_oe_out), $past(mc_q)};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read back wrong");

    property p_pins_read;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        s_read_start ##0 wb_adr_in == `SPP_ADR_PINS
        |=> wb_dat_out == {10'h000, $past(io_s), $past(ded_s)};
    endproperty
    a_pins_read: assert property (p_pins_read) else $error("pin levels read back wrong");

    property p_io_sync;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        up_seen && $past(up_seen) |-> io_s == $past(io_in, 2);
    endproperty
    a_io_sync: assert property (p_io_sync) else $error("two-way pin latency wrong");

    property p_ack_idle;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        !wb_cyc_in && !wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without a request");

    property p_clear_all;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        term_val[`SPP_TERM_AR] |-> mc_q == 10'h000;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear term missed a register");

    property p_preset_all;
        @(posedge ref_clk_in) disable iff (!nrst_in)
        term_val[`SPP_TERM_SP] && !term_val[`SPP_TERM_AR] ##1 !term_val[`SPP_TERM_AR]
        |-> mc_q == 10'h3ff;
    endproperty
    a_preset_all: assert property (p_preset_all) else $error("preset missed a register");
endmodule

// ---- spp_board.sv ----
// Purpose: board logic around the two-way pins of the macrocell array
// Assumes: the bench says which pins the board drives and with what level
// Notes: an undriven pin flips on every event, so a stale level is never seen
`timescale 1ns/1ps
module spp_board (
    // pin side of the array
    input wire logic [9:0] pin_drv_in,
    input wire logic [9:0] pin_oe_in,
    // board drive
    input wire logic [9:0] brd_val_in,
    input wire logic [9:0] brd_en_in,
    // resolved pin level
    output logic [9:0] pin_out
);
    initial pin_out = 10'h000;
    // array driver first, then board, else floating
    always @(pin_drv_in, pin_oe_in, brd_val_in, brd_en_in) begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe_in[i]) begin
                pin_out[i] = pin_drv_in[i];
            end else if (brd_en_in[i]) begin
                pin_out[i] = brd_val_in[i];
            end else begin
                pin_out[i] = ~pin_out[i];
            end
        end
    end
endmodule

// ---- programmable_sum_of_products_macrocells_tb.sv ----
// Purpose: self-checking bench for the macrocell array
// Assumes: fuses reset to all ones, so every term starts false
// Notes: inputs pass two sync flops, so settle() waits three edges; the async clear check waits two
`timescale 1ns/1ps
`include "spp_cfg.svh"
module programmable_sum_of_products_macrocells_tb;
    import spp_pkg::*;
    localparam int LIMIT = 5000;
    logic ref_clk_in, nrst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, pol, bq;
    logic [11:0] wb_adr_in;
    logic [3:0] wb_sel_in;
    logic [3:0] sel_v;
    logic [31:0] wb_dat_in, wb_dat_out, r;
    spp_ded_t ded_in;
    spp_mc_t io_in, io_out, io_oe_out, brd_val, brd_en;
    int err_total, compares, cycles, seed;

    spp_array dut_u (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .ded_in(ded_in), .io_in(io_in), .io_out(io_out),
        .io_oe_out(io_oe_out));
    spp_board brd_u (.pin_drv_in(io_out), .pin_oe_in(io_oe_out), .brd_val_in(brd_val),
        .brd_en_in(brd_en), .pin_out(io_in));

    // ----------------------------------------
    // clock, timeout, verdict
    // ----------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic results();
        $display("compares=%0d errors=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            results();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected=%h seen=%h", nm, exp, seen);
        end
    endtask

    // one classic cycle; the next call's edge gives the idle cycle
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge ref_clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_sel_in <= sel_v;
        wb_dat_in <= d;
        do @(posedge ref_clk_in); while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
    endtask

    // low word then high word of one product term
    task automatic term(input int t, input logic [43:0] f);
        logic [31:0] q;
        wb(1'b1, 12'(8 * t), f[31:0], q);
        wb(1'b1, 12'(8 * t + 4), {20'h0_0000, f[11+32:32]}, q);
    endtask

    // enable term index of macrocell m, sizes mirrored 8..16
    function automatic int tb_base(input int m);
        int b;
        b = 1;
        for (int j = 0; j < m; j++) begin
            b += 9 + 2 * ((j < 9 - j) ? j : 9 - j);
        end
        return b;
    endfunction

    task automatic settle();
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h0000_c3ec;
        {nrst_in, wb_cyc_in, wb_stb_in, wb_we_in} = 4'h0;
        wb_adr_in = 12'h000;
        wb_sel_in = 4'hf;
        sel_v = 4'hf;
        wb_dat_in = 32'h0000_0000;
        ded_in = 12'h000;
        brd_val = 10'h000;
        brd_en = 10'h000;
        cycles = 0;
        repeat (20) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk("oe_reset", 32'(io_oe_out), 32'h0000_0000);
        chk("out_reset", 32'(io_out), 32'h0000_03ff);
        wb(1'b0, `SPP_ADR_STAT, 32'h0000_0000, r);
        chk("stat_reset", r, 32'h0000_0000);
        wb(1'b1, `SPP_ADR_CFG, 32'hffff_ffff, r);
        wb(1'b0, `SPP_ADR_CFG, 32'h0000_0000, r);
        chk("cfg_rw", r, 32'h000f_ffff);
        wb(1'b1, 12'h900, 32'h1234_5678, r);
        wb(1'b0, 12'h900, 32'h0000_0000, r);
        chk("unmapped", r, 32'h0000_0000);
        sel_v = 4'h2;
        wb(1'b1, `SPP_ADR_CFG, 32'h0000_0000, r);
        sel_v = 4'hf;
        wb(1'b0, `SPP_ADR_CFG, 32'h0000_0000, r);
        chk("cfg_sel", r, 32'h000f_00ff);
        wb(1'b1, `SPP_ADR_CFG, 32'h0000_0000, r);
        // mc0 toggles on its own feedback, mc2 follows pin 1, mc4 widest last term
        term(tb_base(0), 44'h000_0000_0000);
        term(tb_base(0) + 1, 44'h000_0200_0000);
        term(tb_base(2), 44'h000_0000_0000);
        term(tb_base(2) + 1, 44'h000_0400_0000);
        term(tb_base(4), 44'h000_0000_0000);
        term(tb_base(4) + 16, 44'h000_0000_0001);
        brd_en <= 10'h002;
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            wb(1'b1, `SPP_ADR_CFG, 32'h0000_1416 | (32'(pol) << 14), r);
            repeat (6) begin
                @(posedge ref_clk_in);
                r = $random(seed);
                ded_in <= r[11:0];
                brd_val <= r[21:12];
                settle();
                chk("comb_pol", 32'(io_out[4]), 32'(r[0] == pol));
                chk("pin_feedback", 32'(io_out[2]), 32'(r[13]));
                chk("oe_terms", 32'(io_oe_out), 32'h0000_0015);
            end
        end
        // registered feedback flips the output at every edge
        for (int k = 0; k < 4; k++) begin
            bq = io_out[0];
            @(posedge ref_clk_in);
            #1;
            chk("toggle", 32'(io_out[0]), 32'(!bq));
        end
        term(`SPP_TERM_SP, 44'h000_0000_0000);
        wb(1'b0, `SPP_ADR_STAT, 32'h0000_0000, r);
        chk("preset", r & 32'h0000_03ff, 32'h0000_03ff);
        @(posedge ref_clk_in);
        ded_in <= 12'h000;
        settle();
        wb(1'b0, `SPP_ADR_PINS, 32'h0000_0000, r);
        chk("pins_ded", r & 32'h0000_0fff, 32'h0000_0000);
        term(`SPP_TERM_AR, 44'h000_0000_0004);
        @(posedge ref_clk_in);
        ded_in <= 12'h002;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("async_clear", 32'(io_out[0]), 32'h0000_0000);
        wb(1'b0, `SPP_ADR_STAT, 32'h0000_0000, r);
        chk("clear_wins", r & 32'h0000_03ff, 32'h0000_0000);
        results();
    end
endmodule
